// [hdl/eiss_line_mux.sv]
// One interrupt line source multiplexer driven by a 4-bit selector field.
module eiss_line_mux
  import eiss_pkg::*;
#(
  parameter bit HAS_PORT_F = 1'b1
) (
  // Selector field as stored.
  input wire logic [SEL_W-1:0] sel,
  // Candidate pin levels of the same index.
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_c,
  input wire logic pin_f,
  // Chosen level, low for reserved codes.
  output logic level
);

  // The top code bit is ignored, so only the low three bits decode.
  always_comb begin
    unique case (sel[2:0])
      CODE_PORT_A: level = pin_a;
      CODE_PORT_B: level = pin_b;
      CODE_PORT_C: level = pin_c;
      // Port F exists only for the lower group of lines.
      CODE_PORT_F: level = HAS_PORT_F ? pin_f : 1'b0;
      // Reserved codes hold the line inactive so no edge is seen.
      default: level = 1'b0;
    endcase
  end

endmodule // eiss_line_mux

// [hdl/eiss_pkg.sv]
// Package with register map, field layout, select codes and carriers for the interrupt line source selectors.
package eiss_pkg;

  // Width of the byte address that the register slave decodes.
  localparam int ADDR_W = 8;

  // Byte offsets of the two selector registers.
  localparam logic [ADDR_W-1:0] OFF_SEL_4_TO_7 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SEL_8_TO_11 = 8'h10;

  // Reset value of the stored selector fields.
  localparam logic [15:0] SEL_RESET = 16'h0000;

  // Reserved upper half of each register, read back as zero.
  localparam logic [15:0] RSVD_READ = 16'h0000;

  // Field geometry: four 4-bit selectors per register, low code bits decode.
  localparam int SEL_W = 4;
  localparam int SELS_PER_REG = 4;
  localparam int LINE_COUNT = 8;
  localparam int FIRST_LINE = 4;

  // Lines below this index also offer port F.
  localparam int PORT_F_LIMIT = 8;

  // Source codes after dropping the ignored top bit.
  localparam logic [2:0] CODE_PORT_A = 3'h0;
  localparam logic [2:0] CODE_PORT_B = 3'h1;
  localparam logic [2:0] CODE_PORT_C = 3'h2;
  localparam logic [2:0] CODE_PORT_F = 3'h5;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Full-word write strobe.
  localparam logic [3:0] STRB_WORD = 4'hf;

  // Pin levels of the four GPIO ports, indexed by pin number.
  typedef struct packed {
    logic [15:0] port_f;
    logic [15:0] port_c;
    logic [15:0] port_b;
    logic [15:0] port_a;
  } eiss_pins_t;

endpackage : eiss_pkg

// [hdl/eiss_top.sv]
// Interrupt line 4..11 source selector registers with AXI4-Lite slave and pin routing.
//
// What this block does
// - Lines 4-7 selector at 0x0C, resets zero.
// - Bits 15:12 route line 7: A/B/C/F.
// - Bits 11:8 route line 6: A/B/C/F.
// - Bits 7:4 route line 5: A/B/C/F.
// - Bits 3:0 route line 4: A/B/C/F.
// - Lines 8-11 selector at 0x10, resets zero.
module eiss_top
  import eiss_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // AXI4-Lite write address channel.
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address channel.
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // GPIO pin levels.
  input eiss_pins_t gpio_pins,
  // Interrupt lines 4..11 towards the edge detector, bit 0 is line 4.
  output logic [LINE_COUNT-1:0] irq_line_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State declarations.

  // Stored selector fields; the reserved upper halves are not stored.
  logic [15:0] sel_lo_reg, sel_lo_next;
  logic [15:0] sel_hi_reg, sel_hi_next;
  // Write address and data holding, so the channels arrive in any order.
  logic aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  // Channel handshake flops.
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Registered interrupt line levels.
  logic [LINE_COUNT-1:0] irq_reg, irq_next;
  // A write commits when both halves are held and no response waits.
  logic wr_do;
  // Byte-lane merge of the held data over a stored field.
  logic [15:0] lane_mask;

  assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken independently, then committed.

  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    sel_lo_next = sel_lo_reg;
    sel_hi_next = sel_hi_reg;
    // Take the address when offered and the holder is free.
    if (awvalid && awready_reg) begin
      aw_hold_next = 1'b1;
      aw_addr_next = awaddr;
    end
    // Take the data when offered and the holder is free.
    if (wvalid && wready_reg) begin
      w_hold_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    // Commit; byte lanes are honoured though software should write whole words.
    if (wr_do) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if ({aw_addr_reg[ADDR_W-1:2], 2'b00} == OFF_SEL_4_TO_7) begin
        sel_lo_next = (sel_lo_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
      end else if ({aw_addr_reg[ADDR_W-1:2], 2'b00} == OFF_SEL_8_TO_11) begin
        sel_hi_next = (sel_hi_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
      end else begin
        // Unmapped offsets change nothing and answer with an error.
        bresp_next = RESP_SLVERR;
      end
    end
    // Response leaves once the master accepts it.
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    // Ready reflects the holder being free in the coming cycle.
    awready_next = !aw_hold_next;
    wready_next = !w_hold_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: one read at a time, answered the cycle after it is taken.

  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      // Reserved upper halves read as zero.
      if ({araddr[ADDR_W-1:2], 2'b00} == OFF_SEL_4_TO_7) begin
        rdata_next = {RSVD_READ, sel_lo_reg};
      end else if ({araddr[ADDR_W-1:2], 2'b00} == OFF_SEL_8_TO_11) begin
        rdata_next = {RSVD_READ, sel_hi_reg};
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source routing: one multiplexer per line.

  generate
    for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
      localparam int LINE = FIRST_LINE + i;
      logic [SEL_W-1:0] sel_field;
      // Lines 4..7 sit in the low register, 8..11 in the high one.
      if (i < SELS_PER_REG) begin : g_lo
        assign sel_field = sel_lo_reg[i*SEL_W +: SEL_W];
      end else begin : g_hi
        assign sel_field = sel_hi_reg[(i-SELS_PER_REG)*SEL_W +: SEL_W];
      end
      eiss_line_mux #(
        .HAS_PORT_F(LINE < PORT_F_LIMIT)
      ) u_mux (
        .sel(sel_field),
        .pin_a(gpio_pins.port_a[LINE]),
        .pin_b(gpio_pins.port_b[LINE]),
        .pin_c(gpio_pins.port_c[LINE]),
        .pin_f(gpio_pins.port_f[LINE]),
        .level(irq_next[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // State registers; the line outputs cost one cycle of latency to stay glitch free.

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel_lo_reg <= SEL_RESET;
      sel_hi_reg <= SEL_RESET;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
      irq_reg <= '0;
    end else begin
      sel_lo_reg <= sel_lo_next;
      sel_hi_reg <= sel_hi_next;
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs straight from flops.
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq_line_out = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_SEL_LO_WRITE: assert property (wr_do && w_strb_reg == STRB_WORD && aw_addr_reg == OFF_SEL_4_TO_7 |=>
    sel_lo_reg == $past(w_data_reg[15:0]) && rdata_reg[31:16] == RSVD_READ)
    else $error("Lines 4-7 selector did not take the written word.");

  AST_SEL_HI_WRITE: assert property (wr_do && w_strb_reg == STRB_WORD && aw_addr_reg == OFF_SEL_8_TO_11 |=>
    sel_hi_reg == $past(w_data_reg[15:0]) && bvalid_reg && bresp_reg == RESP_OKAY)
    else $error("Lines 8-11 selector did not take the written word.");

  AST_LINE7_PORT_F: assert property (sel_lo_reg[14:12] == CODE_PORT_F |=>
    irq_line_out[3] == $past(gpio_pins.port_f[7]))
    else $error("Line 7 does not follow port F pin 7.");

  AST_LINE6_PORT_B: assert property (sel_lo_reg[10:8] == CODE_PORT_B |=>
    irq_line_out[2] == $past(gpio_pins.port_b[6]))
    else $error("Line 6 does not follow port B pin 6.");

  AST_LINE5_PORT_C: assert property (sel_lo_reg[6:4] == CODE_PORT_C |=>
    irq_line_out[1] == $past(gpio_pins.port_c[5]))
    else $error("Line 5 does not follow port C pin 5.");

  AST_LINE4_PORT_A: assert property (sel_lo_reg[2:0] == CODE_PORT_A ##1 sel_lo_reg[2:0] == CODE_PORT_A |->
    irq_line_out[0] == $past(gpio_pins.port_a[4]))
    else $error("Line 4 does not follow port A pin 4.");

  AST_LINE9_PORT_B: assert property (sel_hi_reg[6:4] == CODE_PORT_B |=>
    irq_line_out[5] == $past(gpio_pins.port_b[9]))
    else $error("Line 9 does not follow port B pin 9.");

  AST_RESERVED_LOW: assert property (sel_hi_reg[2:0] == CODE_PORT_F |=>
    !irq_line_out[4])
    else $error("Line 8 is not held low for a reserved code.");

  COV_WRITE_DONE: cover property (bvalid_reg && bready && bresp_reg == RESP_OKAY);
  COV_READ_DONE: cover property (rvalid_reg && rready && rresp_reg == RESP_OKAY);
  COV_LINE4_F: cover property (sel_lo_reg[2:0] == CODE_PORT_F ##1 irq_line_out[0]);

endmodule // eiss_top

// [tb/eiss_edge_model.sv]
// Behavioural model of the edge detector that watches the interrupt lines.
module eiss_edge_model
  import eiss_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Lines arriving from the selector block.
  input wire logic [LINE_COUNT-1:0] irq_line_in,
  // Line levels as the detector last sampled them.
  output logic [LINE_COUNT-1:0] seen_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Next sampled levels.
  logic [LINE_COUNT-1:0] seen_next;
  // The detector samples every edge, because it has no filter of its own.
  always_comb begin
    seen_next = irq_line_in;
  end
  // Register the sampled levels; reset clears them.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seen_reg <= '0;
    end else begin
      seen_reg <= seen_next;
    end
  end
endmodule // eiss_edge_model

// [tb/eiss_top_tb_top.sv]
// Self-checking bench for the interrupt line source selectors.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module eiss_top_tb_top
  import eiss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Pin pattern with a different 16-bit value on every port.
  localparam eiss_pins_t PAT = 64'h9669_0ff0_3c3c_5a5a;
  // Bench-driven inputs, all defined at time zero.
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  eiss_pins_t pins = '0;
  // Design outputs.
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [LINE_COUNT-1:0] irq, seen;
  // Counters and the selector values software believes are programmed.
  int n_mismatch = 0;
  int checked = 0;
  logic [15:0] r1 = '0;
  logic [15:0] r2 = '0;

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  eiss_top dut_u (.sys_clk(sys_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .gpio_pins(pins), .irq_line_out(irq));
  eiss_edge_model model_u (.sys_clk(sys_clk), .reset(reset), .irq_line_in(irq), .seen_reg(seen));

  ////////////////////////////////////////////////////////////////////////////
  // Expected line levels worked out from the code tables.
  function automatic logic [7:0] exp_lines(logic [15:0] s1, logic [15:0] s2, eiss_pins_t p);
    logic [7:0] e;
    logic [3:0] s;
    int k;
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? s1[4*i+:4] : s2[4*(i-4)+:4];
      k = FIRST_LINE + i;
      case (s[2:0])
        CODE_PORT_A: e[i] = p.port_a[k];
        CODE_PORT_B: e[i] = p.port_b[k];
        CODE_PORT_C: e[i] = p.port_c[k];
        CODE_PORT_F: e[i] = (k < PORT_F_LIMIT) ? p.port_f[k] : 1'b0;
        default: e[i] = 1'b0;
      endcase
    end
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write one full word; the upper half is always sent as zero.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= STRB_WORD;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released at the edge where it is taken; only the watchdog ends a stuck wait.
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  // Read one word and compare data and response.
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask

  // Program both selectors and read them back.
  task automatic prog(input logic [15:0] a1, input logic [15:0] a2);
    r1 = a1;
    r2 = a2;
    wr(OFF_SEL_4_TO_7, a1, RESP_OKAY);
    wr(OFF_SEL_8_TO_11, a2, RESP_OKAY);
    rdc(OFF_SEL_4_TO_7, {RSVD_READ, a1}, RESP_OKAY);
    rdc(OFF_SEL_8_TO_11, {RSVD_READ, a2}, RESP_OKAY);
  endtask

  // Let pins and selectors settle through the output register, then compare.
  task automatic lines_chk();
    repeat (3) @(posedge sys_clk);
    `CHK(irq, exp_lines(r1, r2, pins))
    `CHK(seen, exp_lines(r1, r2, pins))
  endtask

  // Print counts and the verdict, then stop.
  task automatic finish_test();
    $display("Counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(OFF_SEL_4_TO_7, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_SEL_8_TO_11, 32'h0000_0000, RESP_OKAY);
    @(posedge sys_clk);
    pins <= PAT;
    lines_chk();
    $display("test reset done");
    // Every code in every field, with a pin pattern and its inverse.
    for (int c = 0; c < 16; c++) begin
      prog({4{c[3:0]}}, {4{c[3:0]}});
      for (int j = 0; j < 2; j++) begin
        @(posedge sys_clk);
        pins <= (j == 1) ? ~PAT : PAT;
        lines_chk();
      end
    end
    $display("test codes done");
    // Different codes per field, one port high at a time.
    prog(16'hd218, 16'h0a35);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      pins <= 64'hffff << (16 * k);
      lines_chk();
    end
    $display("test fields done");
    // An unmapped word is refused and leaves the selectors alone.
    wr(8'h14, 16'hffff, RESP_SLVERR);
    rdc(8'h14, 32'h0000_0000, RESP_SLVERR);
    rdc(OFF_SEL_4_TO_7, {RSVD_READ, r1}, RESP_OKAY);
    lines_chk();
    $display("test unmapped done");
    // A reset in mid-run clears programmed selectors; pins stay low while it is applied.
    @(posedge sys_clk);
    pins <= '0;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    r1 = '0;
    r2 = '0;
    rdc(OFF_SEL_4_TO_7, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_SEL_8_TO_11, 32'h0000_0000, RESP_OKAY);
    @(posedge sys_clk);
    pins <= PAT;
    lines_chk();
    $display("test reset again done");
    finish_test();
  end

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end
endmodule // eiss_top_tb_top
